// ===== als_top.sv
// light sensor top: serial target, control registers, sequencer
`include "als_map.svh"
`default_nettype none

module als_top
    import als_pkg::*;
#(
    parameter logic [6:0] TARGET_ADDR = 7'h2A,
    // arbitrary identification value
    parameter logic [7:0] ID_VALUE = 8'h5A,
    parameter int TICK_CYCLES = `ALS_TICK_CYCLES
)
(
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic light_pulse_in,
    output logic sda_out,
    output logic sda_oe_n_out,
    output logic result_done_out
);

    initial
    begin
        if (TARGET_ADDR[6:3] == 4'h0 || TARGET_ADDR[6:3] == 4'hF)
            $error("TARGET_ADDR falls in a reserved range");
    end

    logic [2:0] scl_q;
    logic [2:0] sda_q;
    logic [2:0] light_q;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic light_edge;

    // [0] feeds [1] only; logic reads [1] and [2]
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            scl_q <= 3'h7;
            sda_q <= 3'h7;
            light_q <= 3'h0;
        end
        else
        begin
            scl_q <= {scl_q[1:0], scl_in};
            sda_q <= {sda_q[1:0], sda_in};
            light_q <= {light_q[1:0], light_pulse_in};
        end
    end

    assign scl_rise = scl_q[1] && !scl_q[2];
    assign scl_fall = !scl_q[1] && scl_q[2];
    assign start_det = scl_q[1] && scl_q[2] && !sda_q[1] && sda_q[2];
    assign stop_det = scl_q[1] && scl_q[2] && sda_q[1] && !sda_q[2];
    assign light_edge = light_q[1] && !light_q[2];

    als_i2c_state_t ist_q;
    logic [7:0] shift_q;
    logic [7:0] tx_q;
    logic [2:0] bit_q;
    logic got_q;
    logic rw_q;
    logic first_q;
    logic nack_q;
    logic [3:0] ptr_q;
    logic [1:0] mode_q;
    logic skip_q;
    logic [1:0] tsel_q;
    logic [7:0] shadow_hi_q;
    logic [15:0] result;
    logic seq_done;
    logic seq_active;
    logic [7:0] rd_byte;
    logic wr_stb;
    logic load_stb;
    logic addr_hit;

    function automatic logic [3:0] next_ptr(input logic [3:0] p);
        unique case (p)
            `ALS_REG_CONFIG: next_ptr = `ALS_REG_DATA_LO;
            `ALS_REG_DATA_HI: next_ptr = `ALS_REG_ID;
            4'hD: next_ptr = `ALS_REG_CONTROL;
            default: next_ptr = p + 4'h1;
        endcase
    endfunction : next_ptr

    always_comb
    begin
        unique case (ptr_q)
            `ALS_REG_CONTROL: rd_byte = {6'h00, mode_q};
            `ALS_REG_CONFIG: rd_byte = {4'h0, skip_q, 1'b0, tsel_q};
            `ALS_REG_DATA_LO: rd_byte = result[7:0];
            `ALS_REG_DATA_HI: rd_byte = shadow_hi_q;
            `ALS_REG_ID: rd_byte = ID_VALUE;
            default: rd_byte = 8'h00;
        endcase
    end

    assign addr_hit = shift_q[7:1] == TARGET_ADDR;
    assign wr_stb = scl_fall && ist_q == I2C_WR && got_q;
    assign load_stb = scl_fall && ((ist_q == I2C_ACK && rw_q)
        || (ist_q == I2C_RACK && !nack_q));

    // sample on the rising clock edge, change data on the falling one
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            ist_q <= I2C_IDLE;
            shift_q <= 8'h00;
            tx_q <= 8'h00;
            bit_q <= 3'h0;
            got_q <= 1'b0;
            rw_q <= 1'b0;
            first_q <= 1'b0;
            nack_q <= 1'b0;
            sda_oe_n_out <= 1'b1;
        end
        else if (start_det)
        begin
            ist_q <= I2C_ADDR;
            bit_q <= 3'h0;
            got_q <= 1'b0;
            sda_oe_n_out <= 1'b1;
        end
        else if (stop_det)
        begin
            ist_q <= I2C_IDLE;
            sda_oe_n_out <= 1'b1;
        end
        else if (scl_rise)
        begin
            if (ist_q == I2C_ADDR || ist_q == I2C_WR)
            begin
                shift_q <= {shift_q[6:0], sda_q[1]};
                bit_q <= bit_q + 3'h1;
                got_q <= bit_q == 3'h7;
            end
            if (ist_q == I2C_RACK)
                nack_q <= sda_q[1];
        end
        else if (scl_fall)
        begin
            unique case (ist_q)
                I2C_IDLE: ;
                I2C_ADDR:
                    if (got_q)
                    begin
                        got_q <= 1'b0;
                        rw_q <= shift_q[0];
                        first_q <= 1'b1;
                        ist_q <= addr_hit ? I2C_ACK : I2C_IDLE;
                        sda_oe_n_out <= !addr_hit;
                    end
                I2C_WR:
                    if (got_q)
                    begin
                        got_q <= 1'b0;
                        first_q <= 1'b0;
                        ist_q <= I2C_ACK;
                        sda_oe_n_out <= 1'b0;
                    end
                I2C_ACK:
                begin
                    bit_q <= 3'h0;
                    if (rw_q)
                    begin
                        ist_q <= I2C_RD;
                        tx_q <= {rd_byte[6:0], 1'b1};
                        sda_oe_n_out <= rd_byte[7];
                    end
                    else
                    begin
                        ist_q <= I2C_WR;
                        sda_oe_n_out <= 1'b1;
                    end
                end
                I2C_RD:
                    if (bit_q == 3'h7)
                    begin
                        ist_q <= I2C_RACK;
                        sda_oe_n_out <= 1'b1;
                    end
                    else
                    begin
                        bit_q <= bit_q + 3'h1;
                        tx_q <= {tx_q[6:0], 1'b1};
                        sda_oe_n_out <= tx_q[7];
                    end
                I2C_RACK:
                    if (nack_q)
                        ist_q <= I2C_IDLE;
                    else
                    begin
                        ist_q <= I2C_RD;
                        bit_q <= 3'h0;
                        tx_q <= {rd_byte[6:0], 1'b1};
                        sda_oe_n_out <= rd_byte[7];
                    end
                default: ist_q <= I2C_IDLE;
            endcase
        end
    end

    // open-drain: the pin is only ever pulled low
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
            sda_out <= 1'b0;
        else
            sda_out <= 1'b0;
    end

    // a host write to control in the same cycle as the single-run clear
    // wins; a write elsewhere must not swallow the clear
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            ptr_q <= 4'h0;
            mode_q <= `ALS_MODE_DOWN;
            skip_q <= 1'b0;
            tsel_q <= `ALS_TSEL_400;
        end
        else
        begin
            if (seq_done && mode_q == `ALS_MODE_SINGLE)
                mode_q <= `ALS_MODE_DOWN;
            if (wr_stb && first_q && shift_q[`ALS_CMD_SELECT_BIT])
                ptr_q <= shift_q[3:0];
            else if (wr_stb)
            begin
                ptr_q <= next_ptr(ptr_q);
                if (ptr_q == `ALS_REG_CONTROL)
                    mode_q <= shift_q[1:0];
                if (ptr_q == `ALS_REG_CONFIG)
                begin
                    skip_q <= shift_q[`ALS_CFG_SKIP_BIT];
                    tsel_q <= shift_q[1:0];
                end
            end
            else if (load_stb)
                ptr_q <= next_ptr(ptr_q);
        end
    end

    // high byte frozen when the low byte is fetched
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
            shadow_hi_q <= `ALS_RST_BYTE;
        else if (load_stb && ptr_q == `ALS_REG_DATA_LO)
            shadow_hi_q <= result[15:8];
    end

    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
            result_done_out <= 1'b0;
        else
            result_done_out <= seq_done;
    end

    als_seq #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_seq (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .mode_in(mode_q),
        .tsel_in(tsel_q),
        .skip_in(skip_q),
        .light_edge_in(light_edge),
        .result_out(result),
        .done_out(seq_done),
        .active_out(seq_active)
    );

    a_ack_pulls_low: assert property (
        @(posedge clk_in) disable iff (reset_in)
        ist_q == I2C_ADDR && got_q && scl_fall && addr_hit && !start_det
        && !stop_det |=> ist_q == I2C_ACK && !sda_oe_n_out)
        else $error("address match not acknowledged");

    a_idle_released: assert property (
        @(posedge clk_in) disable iff (reset_in)
        ist_q == I2C_IDLE && $past(ist_q) == I2C_IDLE |-> sda_oe_n_out)
        else $error("data line held while idle");

    a_single_clears: assert property (
        @(posedge clk_in) disable iff (reset_in)
        seq_done && mode_q == `ALS_MODE_SINGLE && !wr_stb
        |=> mode_q == `ALS_MODE_DOWN ##1 !seq_active)
        else $error("single run did not return to power-down");

    a_down_stays_idle: assert property (
        @(posedge clk_in) disable iff (reset_in)
        mode_q == `ALS_MODE_DOWN && !seq_active |=> !seq_active)
        else $error("sequencer started in power-down");

endmodule : als_top

`default_nettype wire

// ===== als_map.svh
// register map, field positions, reset values and timing figures
`ifndef ALS_MAP_SVH
`define ALS_MAP_SVH

// time base
`define ALS_CLK_PERIOD_NS 10
`define ALS_MS_NS 1_000_000
`define ALS_TICK_CYCLES (`ALS_MS_NS / `ALS_CLK_PERIOD_NS)

// integration periods in ms (400, 200, 100)
`define ALS_TINT_400_MS 9'h190
`define ALS_TINT_200_MS 9'h0C8
`define ALS_TINT_100_MS 9'h064
// power-save interval in ms at scale 1 (60), divided by the scale
`define ALS_PSAVE_MS 9'h03C

// integration time select codes
`define ALS_TSEL_400 2'h0
`define ALS_TSEL_200 2'h1
`define ALS_TSEL_100 2'h2

// operating mode codes
`define ALS_MODE_DOWN 2'h0
`define ALS_MODE_SINGLE 2'h2
`define ALS_MODE_CONT 2'h3

// register offsets behind the serial interface
`define ALS_REG_CONTROL 4'h0
`define ALS_REG_CONFIG 4'h1
`define ALS_REG_DATA_LO 4'h4
`define ALS_REG_DATA_HI 4'h5
`define ALS_REG_ID 4'hA

// field positions
`define ALS_CMD_SELECT_BIT 7
`define ALS_CFG_SKIP_BIT 3

// reset values
`define ALS_RST_BYTE 8'h00
`define ALS_RST_RESULT 16'h0000

`endif

// ===== als_pkg.sv
// state types shared by the light sensor design
`default_nettype none

package als_pkg;

    typedef enum logic [1:0] {
        SEQ_DOWN,
        SEQ_INTEG,
        SEQ_SAVE
    } als_seq_state_t;

    typedef enum logic [2:0] {
        I2C_IDLE,
        I2C_ADDR,
        I2C_WR,
        I2C_ACK,
        I2C_RD,
        I2C_RACK
    } als_i2c_state_t;

endpackage : als_pkg

`default_nettype wire

// ===== als_seq.sv
// acquisition sequencer: integration, power-save interval, result
`include "als_map.svh"
`default_nettype none

module als_seq
    import als_pkg::*;
#(
    parameter int TICK_CYCLES = `ALS_TICK_CYCLES
)
(
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic [1:0] mode_in,
    input wire logic [1:0] tsel_in,
    input wire logic skip_in,
    input wire logic light_edge_in,
    output logic [15:0] result_out,
    output logic done_out,
    output logic active_out
);

    localparam int TW = $clog2(TICK_CYCLES + 1);

    initial
    begin
        if (TICK_CYCLES < 2)
            $error("TICK_CYCLES must be at least 2");
    end

    function automatic logic [8:0] tint_f(input logic [1:0] t);
        unique case (t)
            `ALS_TSEL_200: tint_f = `ALS_TINT_200_MS;
            `ALS_TSEL_100: tint_f = `ALS_TINT_100_MS;
            default: tint_f = `ALS_TINT_400_MS;
        endcase
    endfunction : tint_f

    // interval shrinks with result_scale_factor (1, 2, 4)
    function automatic logic [8:0] save_f(input logic [1:0] t);
        unique case (t)
            `ALS_TSEL_200: save_f = `ALS_PSAVE_MS >> 1;
            `ALS_TSEL_100: save_f = `ALS_PSAVE_MS >> 2;
            default: save_f = `ALS_PSAVE_MS;
        endcase
    endfunction : save_f

    als_seq_state_t state_q;
    logic [TW-1:0] tick_cnt_q;
    logic [8:0] ms_q;
    logic [8:0] tint_q;
    logic [8:0] save_q;
    logic [15:0] count_q;
    logic tick;
    logic go;
    logic [8:0] limit;
    logic end_ph;

    assign tick = tick_cnt_q == TW'(TICK_CYCLES - 1);
    assign go = mode_in == `ALS_MODE_SINGLE || mode_in == `ALS_MODE_CONT;
    assign limit = (state_q == SEQ_SAVE) ? save_q : tint_q;
    assign end_ph = tick && state_q != SEQ_DOWN && ms_q == limit - 9'h001;
    assign active_out = state_q != SEQ_DOWN;

    // 1 ms enable; restarted from zero so every phase is whole ms
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
            tick_cnt_q <= '0;
        else if (state_q == SEQ_DOWN || tick)
            tick_cnt_q <= '0;
        else
            tick_cnt_q <= tick_cnt_q + TW'(1);
    end

    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
            state_q <= SEQ_DOWN;
        else
        begin
            unique case (state_q)
                // the done cycle blocks a restart while single mode clears
                SEQ_DOWN:
                    if (go && !done_out)
                        state_q <= SEQ_INTEG;
                SEQ_INTEG:
                    if (!go)
                        state_q <= SEQ_DOWN;
                    else if (end_ph)
                    begin
                        if (mode_in != `ALS_MODE_CONT)
                            state_q <= SEQ_DOWN;
                        else if (!skip_in)
                            state_q <= SEQ_SAVE;
                        else
                            state_q <= SEQ_INTEG;
                    end
                SEQ_SAVE:
                    if (mode_in != `ALS_MODE_CONT)
                        state_q <= SEQ_DOWN;
                    else if (end_ph)
                        state_q <= SEQ_INTEG;
            endcase
        end
    end

    // a select change takes effect at the next phase, never mid-phase
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            ms_q <= '0;
            tint_q <= `ALS_TINT_400_MS;
            save_q <= `ALS_PSAVE_MS;
        end
        else
        begin
            if (state_q == SEQ_DOWN || end_ph)
                ms_q <= '0;
            else if (tick)
                ms_q <= ms_q + 9'h001;
            if (state_q == SEQ_DOWN || end_ph)
            begin
                tint_q <= tint_f(tsel_in);
                save_q <= save_f(tsel_in);
            end
        end
    end

    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
            count_q <= `ALS_RST_RESULT;
        else if (state_q != SEQ_INTEG || end_ph)
            count_q <= '0;
        else if (light_edge_in && count_q != 16'hFFFF)
            count_q <= count_q + 16'h0001;
    end

    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            result_out <= `ALS_RST_RESULT;
            done_out <= 1'b0;
        end
        else
        begin
            done_out <= end_ph && state_q == SEQ_INTEG && go;
            if (end_ph && state_q == SEQ_INTEG && go)
                result_out <= count_q;
        end
    end

    a_single_ends_down: assert property (
        @(posedge clk_in) disable iff (reset_in)
        end_ph && state_q == SEQ_INTEG && mode_in == `ALS_MODE_SINGLE
        |=> state_q == SEQ_DOWN ##1 state_q == SEQ_DOWN
            || mode_in != `ALS_MODE_DOWN)
        else $error("single acquisition did not power down");

    a_cont_inserts_save: assert property (
        @(posedge clk_in) disable iff (reset_in)
        end_ph && state_q == SEQ_INTEG && mode_in == `ALS_MODE_CONT
        && !skip_in |=> state_q == SEQ_SAVE && ms_q == 9'h000)
        else $error("no power-save interval after integration");

    a_skip_no_save: assert property (
        @(posedge clk_in) disable iff (reset_in)
        $rose(state_q == SEQ_SAVE) |-> !$past(skip_in))
        else $error("power-save entered with skip set");

    a_tint_100_len: assert property (
        @(posedge clk_in) disable iff (reset_in)
        end_ph && state_q == SEQ_INTEG && tint_q == 9'h064 && go
        |-> ms_q == 9'h063 ##1 done_out)
        else $error("100 ms integration length wrong");

    a_save_scaled: assert property (
        @(posedge clk_in) disable iff (reset_in)
        state_q == SEQ_SAVE && tint_q == 9'h064 && end_ph
        |-> save_q == 9'h00F && ms_q == 9'h00E)
        else $error("power-save interval not 60 ms over scale");

    a_count_saturates: assert property (
        @(posedge clk_in) disable iff (reset_in)
        state_q == SEQ_INTEG && count_q == 16'hFFFF && !end_ph && go
        |=> count_q == 16'hFFFF)
        else $error("result count wrapped past 65535");

endmodule : als_seq

`default_nettype wire

// ===== als_host_model.sv
// host-side serial bus controller model that talks to the light sensor
`default_nettype none

module als_host_model
#(
    parameter int HALF = 8
)
(
    input wire logic clk_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_oe_n_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // both lines released at time zero so the wire floats to the pull-up
    initial
    begin
        scl_out = 1'b1;
        sda_oe_n_out = 1'b1;
    end

    // every change lands just after an edge, never on it
    task automatic step(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : step

    task automatic start_cond;
        sda_oe_n_out = 1'b0;
        step(HALF);
        scl_out = 1'b0;
        step(2);
    endtask : start_cond

    task automatic stop_cond;
        sda_oe_n_out = 1'b0;
        step(HALF);
        scl_out = 1'b1;
        step(HALF);
        sda_oe_n_out = 1'b1;
        step(HALF);
    endtask : stop_cond

    // data moves only two cycles after the clock falls, so the target never
    // sees it change while the clock is still high
    task automatic bit_io(input logic b, output logic r);
        sda_oe_n_out = b;
        step(HALF);
        scl_out = 1'b1;
        step(HALF);
        r = sda_in;
        scl_out = 1'b0;
        step(2);
    endtask : bit_io

    task automatic byte_io(input logic [7:0] d, input logic ack_in,
                           output logic [7:0] q, output logic ack_out);
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], q[i]);
        bit_io(ack_in, ack_out);
    endtask : byte_io

    task automatic write1(input logic [6:0] a, input logic [7:0] cmd,
                          input logic [7:0] d, output logic nak);
        logic [7:0] q;
        logic n0, n1, n2;
        start_cond();
        byte_io({a, 1'b0}, 1'b1, q, n0);
        byte_io(cmd, 1'b1, q, n1);
        byte_io(d, 1'b1, q, n2);
        stop_cond();
        nak = n0 | n1 | n2;
    endtask : write1

    // sets the pointer, then reads two bytes: acked low, nacked high
    task automatic read2(input logic [6:0] a, input logic [7:0] cmd,
                         output logic [15:0] val, output logic nak);
        logic [7:0] q;
        logic n0, n1, n2, x;
        start_cond();
        byte_io({a, 1'b0}, 1'b1, q, n0);
        byte_io(cmd, 1'b1, q, n1);
        stop_cond();
        start_cond();
        byte_io({a, 1'b1}, 1'b1, q, n2);
        byte_io(8'hFF, 1'b0, val[7:0], x);
        byte_io(8'hFF, 1'b1, val[15:8], x);
        stop_cond();
        nak = n0 | n1 | n2;
    endtask : read2

    // the raw count only becomes lux once scaled by the period's factor
    function automatic int lux_of(input logic [15:0] c, input logic [1:0] ts);
        return int'(c) << ts;
    endfunction : lux_of
endmodule : als_host_model

`default_nettype wire

// ===== ambient_light_acquisition_test.sv
// self-checking bench for the light sensor top
`default_nettype none

module ambient_light_acquisition_test;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int TICK = 4;
    localparam logic [6:0] ADDR = 7'h2A;
    // arbitrary identification value
    localparam logic [7:0] ID_VAL = 8'hC3;
    // bit 2 skip flag, bits 1:0 period select
    localparam logic [2:0] CFG [5] = '{3'h2, 3'h1, 3'h0, 3'h6, 3'h4};

    logic clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic light_pulse = 1'b0;
    logic host_scl, host_oe_n, dut_sda, dut_oe_n, done;
    wire logic sda_wire;
    int err_total = 0;
    int n_checks = 0;
    int n_done = 0;
    int cyc = 0;
    int last_t = 0;
    bit have_prev = 1'b0;
    int exp_q[$];

    // open drain with pull-up: low only while someone pulls it
    assign sda_wire = host_oe_n & (dut_oe_n | dut_sda);

    always #5 clk_in = ~clk_in;

    als_top #(.TARGET_ADDR(ADDR), .ID_VALUE(ID_VAL), .TICK_CYCLES(TICK)) dut (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .scl_in(host_scl),
        .sda_in(sda_wire),
        .light_pulse_in(light_pulse),
        .sda_out(dut_sda),
        .sda_oe_n_out(dut_oe_n),
        .result_done_out(done)
    );

    als_host_model #(.HALF(8)) host (
        .clk_in(clk_in),
        .sda_in(sda_wire),
        .scl_out(host_scl),
        .sda_oe_n_out(host_oe_n)
    );

    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD %s expected %0h seen %0h", what, exp, got);
        end
    endtask : check

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop

    task automatic step(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : step

    task automatic wait_done(input int target, input int limit);
        for (int i = 0; i < limit && n_done < target; i++)
            @(posedge clk_in);
        #1;
        if (n_done < target)
        begin
            err_total++;
            $display("BAD wait_done expected %0d seen %0d", target, n_done);
            report_and_stop();
        end
    endtask : wait_done

    function automatic int cycle_len(input logic [2:0] c);
        int tint;
        tint = 400 >> c[1:0];
        return (tint + (c[2] ? 0 : (60 >> c[1:0]))) * TICK;
    endfunction : cycle_len

    // each result pulse closes one cycle; the oldest note is its length
    // sampled on the falling edge, where the registered pulse has settled
    always @(negedge clk_in)
    begin
        cyc = cyc + 1;
        if (done === 1'b1)
        begin
            n_done = n_done + 1;
            if (have_prev && exp_q.size() > 0)
                check("cycle_len", exp_q.pop_front(), cyc - last_t);
            have_prev = 1'b1;
            last_t = cyc;
        end
    end

    initial
    begin
        logic nak;
        logic [15:0] val;
        int n;
        void'($urandom(32'h65f0_7609));
        repeat (8) @(posedge clk_in);
        #1;
        reset_in = 1'b0;
        step(4);
        host.read2(ADDR, 8'h80, val, nak);
        check("rst_ctrl_cfg", 16'h0000, val);
        host.write1(ADDR ^ 7'h01, 8'h80, 8'h03, nak);
        check("wrong_addr_nak", 1'b1, nak);
        host.write1(ADDR, 8'h80, 8'h01, nak);
        check("ack", 1'b0, nak);
        step(600);
        check("no_run_done", 0, n_done);
        // single run at 100 ms with a random number of light edges
        host.write1(ADDR, 8'h81, 8'h02, nak);
        host.write1(ADDR, 8'h80, 8'h02, nak);
        n = $urandom_range(40, 1);
        repeat (n)
        begin
            light_pulse = 1'b1;
            step(2);
            light_pulse = 1'b0;
            step(2);
        end
        wait_done(1, 1000);
        host.read2(ADDR, 8'h84, val, nak);
        check("result", n, val);
        check("lux", n * 4, host.lux_of(val, 2'h2));
        host.read2(ADDR, 8'h80, val, nak);
        check("mode_back_down", 8'h00, val[7:0]);
        check("cfg_readback", 8'h02, val[15:8]);
        host.read2(ADDR, 8'h8A, val, nak);
        check("id_readback", {8'h00, ID_VAL}, val);
        step(600);
        check("single_done_once", 1, n_done);
        // continuous runs: every period choice with the gap, 100 ms and 400 ms also without it
        for (int k = 0; k < 5; k++)
        begin
            host.write1(ADDR, 8'h80, 8'h00, nak);
            step(4);
            have_prev = 1'b0;
            host.write1(ADDR, 8'h81, {4'h0, CFG[k][2], 1'b0, CFG[k][1:0]}, nak);
            host.write1(ADDR, 8'h80, 8'h03, nak);
            exp_q.push_back(cycle_len(CFG[k]));
            exp_q.push_back(cycle_len(CFG[k]));
            wait_done(n_done + 3, 7000);
            check("queue_drained", 0, exp_q.size());
        end
        report_and_stop();
    end
endmodule : ambient_light_acquisition_test

`default_nettype wire
